// ==== pkg/mcl_pkg.sv ====
// Package with offsets, field layouts, modes and reset values of the macrocell logic block.
package mcl_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] MCL_OFF_MODE   = 8'h00;
  localparam logic [7:0] MCL_OFF_CTRL   = 8'h04;
  localparam logic [7:0] MCL_OFF_CLKSEL = 8'h08;
  localparam logic [7:0] MCL_OFF_OECFG  = 8'h0c;
  localparam logic [7:0] MCL_OFF_STATUS = 8'h10;
  localparam int         MCL_ADDR_W     = 8;

  // Block structure.
  localparam int MCL_NUM_OUT    = 8;
  localparam int MCL_NUM_BURIED = 8;
  localparam int MCL_NUM_CELLS  = MCL_NUM_OUT + MCL_NUM_BURIED;
  localparam int MCL_MAX_TERMS  = 16;

  // Field positions inside the control, clock select and status registers.
  localparam int MCL_CTRL_INV_LSB    = 0;
  localparam int MCL_CTRL_TOG_LSB    = 16;
  localparam int MCL_CLKSEL_SEL_LSB  = 0;
  localparam int MCL_CLKSEL_LAT_LSB  = 16;
  localparam int MCL_STATUS_FB_LSB   = 0;
  localparam int MCL_STATUS_OE_LSB   = 16;
  localparam int MCL_STATUS_GATE_LSB = 24;

  // Storage mode of one macrocell, two bits in the mode register.
  typedef enum logic [1:0] {
    MCL_MODE_COMB  = 2'h0,
    MCL_MODE_REG   = 2'h1,
    MCL_MODE_LATCH = 2'h2,
    MCL_MODE_INPUT = 2'h3
  } mcl_mode_t;

  // Pin driver setting, two bits per pin in the output enable register.
  typedef enum logic [1:0] {
    MCL_OE_ON    = 2'h0,
    MCL_OE_OFF   = 2'h1,
    MCL_OE_TERM0 = 2'h2,
    MCL_OE_TERM1 = 2'h3
  } mcl_oe_t;

  // Values after reset.
  localparam logic [31:0] MCL_RST_MODE   = 32'h0000_0000;
  localparam logic [31:0] MCL_RST_CTRL   = 32'h0000_0000;
  localparam logic [31:0] MCL_RST_CLKSEL = 32'h0000_0000;
  localparam logic [31:0] MCL_RST_OECFG  = 32'h0000_5555;

  // AXI responses.
  localparam logic [1:0] MCL_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MCL_RESP_SLVERR = 2'h2;

endpackage : mcl_pkg

// ==== src/mcl_block.sv ====
// Logic block of eight output and eight buried macrocells with pin drivers and AXI4-Lite setup.
//
// Notes on behaviour
// R1: Output cells give a registered, latched or combinational result.
// R2: Each cell's result may be presented true or inverted.
// R3: Every cell returns its result as feedback in every mode.
// R4: Registered cells may be data-capture or toggle type.
// R5: Each storage element picks one of two shared clock or gate pins.
// R6: Clock or gate pins remain usable as plain data inputs.
// R7: Registers capture only on the rising edge of the selected clock.
// R8: A latch holds its value while its gate is high.
// R9: A latch is transparent while its gate is low.
// R10: Shared reset and preset terms force storage without a clock.
// R11: Buried cells used for logic act like output cells without pins.
// R12: Buried cells may register or latch an external input instead.
// R13: Each pin driver is always on, always off or term controlled.
// R14: Under term control a pin uses whichever of two enable terms is chosen.
// R15: The two enable terms are shared by all pins of the block.
// R16: All storage of the block is initialised together, never singly.
// R17: Eight output cells, eight buried cells, up to sixteen terms each.
// R18: A toggle register inverts on a clock edge when its input is one.
// R19: Reset beats preset when both terms are active.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module mcl_block
  import mcl_pkg::*;
#(
  parameter int NUM_OUT    = MCL_NUM_OUT,
  parameter int NUM_BURIED = MCL_NUM_BURIED
) (
  // Clock and reset.
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  // Summed product terms, one per macrocell, outputs first then buried.
  input  wire logic [MCL_NUM_CELLS-1:0] termSum,
  // Shared control terms of the block.
  input  wire logic                    resetTerm,
  input  wire logic                    presetTerm,
  input  wire logic [1:0]              oeTerm,
  // Clock or gate pins.
  input  wire logic [1:0]              clkGatePin,
  // Pin cells.
  input  wire logic [MCL_NUM_OUT-1:0]  pinIn,
  output logic      [MCL_NUM_OUT-1:0]  pinOut,
  output logic      [MCL_NUM_OUT-1:0]  pinOe,
  // Internal routing.
  output logic      [MCL_NUM_CELLS-1:0] feedback,
  output logic      [1:0]              clkGateData,
  // AXI4-Lite write address channel.
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [MCL_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  // AXI4-Lite write data channel.
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  // AXI4-Lite write response channel.
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic      [1:0]              s_axi_bresp,
  // AXI4-Lite read address channel.
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [MCL_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  // AXI4-Lite read data channel.
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic      [31:0]             s_axi_rdata,
  output logic      [1:0]              s_axi_rresp
);

  // State of the block apart from the macrocell storage, which each cell holds.
  typedef struct packed {
    logic [31:0]               regMode;
    logic [31:0]               regCtrl;
    logic [31:0]               regClkSel;
    logic [31:0]               regOeCfg;
    logic [1:0]                gateLast;
    logic [1:0]                gateData;
    logic [MCL_NUM_OUT-1:0]    oe;
    logic                      awHeld;
    logic [MCL_ADDR_W-1:0]     awAddr;
    logic                      wHeld;
    logic [31:0]               wData;
    logic [3:0]                wStrb;
    logic                      awReady;
    logic                      wReady;
    logic                      bValid;
    logic [1:0]                bResp;
    logic                      arReady;
    logic                      rValid;
    logic [31:0]               rData;
    logic [1:0]                rResp;
  } mcl_block_state_t;

  mcl_block_state_t st;
  mcl_block_state_t next_st;

  logic [MCL_NUM_CELLS-1:0] cellResult;
  logic [1:0]               gateRise;
  logic                     awFire;
  logic                     wFire;
  logic                     arFire;
  logic [2:0]               unusedProt;

  // Protection bits carry no meaning for this block.
  assign unusedProt = s_axi_awprot | s_axi_arprot;

  // Rising edges of the clock or gate pins, seen against the last sampled level.
  assign gateRise = clkGatePin & ~st.gateLast;

  // Channel handshakes.
  assign awFire = s_axi_awvalid & st.awReady;
  assign wFire  = s_axi_wvalid & st.wReady;
  assign arFire = s_axi_arvalid & st.arReady;

  // Merge one written word into a register under its byte strobes.
  function automatic logic [31:0] mclMerge(input logic [31:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
    logic [31:0] merged;
    merged = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merged[8*b +: 8] = data[8*b +: 8];
      end
    end
    return merged;
  endfunction : mclMerge

  // Macrocells: the first group drives pins, the second is buried.
  generate
    for (genvar c = 0; c < MCL_NUM_CELLS; c++) begin : gCell
      localparam bit IS_BURIED = (c >= MCL_NUM_OUT); // R11 R17
      logic sel;
      assign sel = st.regClkSel[MCL_CLKSEL_SEL_LSB + c];
      mcl_cell #(
        .BURIED (IS_BURIED)
      ) uCell (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .mode        (mcl_mode_t'(st.regMode[2*c +: 2])),
        .invert      (st.regCtrl[MCL_CTRL_INV_LSB + c]),
        .toggle      (st.regCtrl[MCL_CTRL_TOG_LSB + c]),
        .clkSel      (sel),
        .inLatch     (IS_BURIED ? st.regClkSel[MCL_CLKSEL_LAT_LSB + (c % MCL_NUM_OUT)] : 1'b0),
        .termSum     (termSum[c]),
        .extIn       (pinIn[c % MCL_NUM_OUT]),
        .gateLevel   (clkGatePin[sel]), // R5
        .gateRise    (gateRise[sel]), // R5
        .blockReset  (resetTerm), // R16
        .blockPreset (presetTerm),
        .result      (cellResult[c])
      );
    end
  endgenerate

  // Next state: clock pin sampling, pin drivers and the AXI4-Lite slave.
  always_comb begin
    next_st = st;
    next_st.gateLast = clkGatePin;
    next_st.gateData = clkGatePin; // R6

    // Pin driver enables from the shared enable terms.
    for (int p = 0; p < MCL_NUM_OUT; p++) begin
      case (mcl_oe_t'(st.regOeCfg[2*p +: 2])) // R13
        MCL_OE_ON:    next_st.oe[p] = 1'b1;
        MCL_OE_OFF:   next_st.oe[p] = 1'b0;
        MCL_OE_TERM0: next_st.oe[p] = oeTerm[0]; // R14 R15
        MCL_OE_TERM1: next_st.oe[p] = oeTerm[1]; // R14 R15
        default:      next_st.oe[p] = 1'b0;
      endcase
    end

    // Write address and data are taken in either order and held.
    if (awFire) begin
      next_st.awHeld  = 1'b1;
      next_st.awAddr  = s_axi_awaddr;
      next_st.awReady = 1'b0;
    end
    if (wFire) begin
      next_st.wHeld  = 1'b1;
      next_st.wData  = s_axi_wdata;
      next_st.wStrb  = s_axi_wstrb;
      next_st.wReady = 1'b0;
    end

    // Perform the write once both halves are held.
    if (st.awHeld && st.wHeld && !st.bValid) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = MCL_RESP_OKAY;
      case ({st.awAddr[MCL_ADDR_W-1:2], 2'b00})
        MCL_OFF_MODE:   next_st.regMode   = mclMerge(st.regMode, st.wData, st.wStrb);
        MCL_OFF_CTRL:   next_st.regCtrl   = mclMerge(st.regCtrl, st.wData, st.wStrb);
        MCL_OFF_CLKSEL: next_st.regClkSel = mclMerge(st.regClkSel, st.wData, st.wStrb);
        MCL_OFF_OECFG:  next_st.regOeCfg  = mclMerge(st.regOeCfg, st.wData, st.wStrb);
        MCL_OFF_STATUS: next_st.bResp     = MCL_RESP_OKAY;
        default:        next_st.bResp     = MCL_RESP_SLVERR;
      endcase
      next_st.regOeCfg[31:2*MCL_NUM_OUT]                = '0;
      next_st.regClkSel[31:MCL_CLKSEL_LAT_LSB+MCL_NUM_BURIED] = '0;
    end

    // Write response ends on its handshake and reopens both channels.
    if (st.bValid && s_axi_bready) begin
      next_st.bValid  = 1'b0;
      next_st.awReady = 1'b1;
      next_st.wReady  = 1'b1;
    end

    // Read: one outstanding, answered in the cycle after the address.
    if (arFire) begin
      next_st.arReady = 1'b0;
      next_st.rValid  = 1'b1;
      next_st.rResp   = MCL_RESP_OKAY;
      case ({s_axi_araddr[MCL_ADDR_W-1:2], 2'b00})
        MCL_OFF_MODE:   next_st.rData = st.regMode;
        MCL_OFF_CTRL:   next_st.rData = st.regCtrl;
        MCL_OFF_CLKSEL: next_st.rData = st.regClkSel;
        MCL_OFF_OECFG:  next_st.rData = st.regOeCfg;
        MCL_OFF_STATUS: begin
          next_st.rData = '0;
          next_st.rData[MCL_STATUS_FB_LSB +: MCL_NUM_CELLS] = cellResult;
          next_st.rData[MCL_STATUS_OE_LSB +: MCL_NUM_OUT]   = st.oe;
          next_st.rData[MCL_STATUS_GATE_LSB +: 2]           = st.gateData;
        end
        default: begin
          next_st.rData = '0;
          next_st.rResp = MCL_RESP_SLVERR;
        end
      endcase
    end
    if (st.rValid && s_axi_rready) begin
      next_st.rValid  = 1'b0;
      next_st.arReady = 1'b1;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st           <= '0;
      st.regMode   <= MCL_RST_MODE;
      st.regCtrl   <= MCL_RST_CTRL;
      st.regClkSel <= MCL_RST_CLKSEL;
      st.regOeCfg  <= MCL_RST_OECFG;
      st.awReady   <= 1'b1;
      st.wReady    <= 1'b1;
      st.arReady   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs, each straight from a flip-flop.
  assign pinOut        = cellResult[MCL_NUM_OUT-1:0]; // R11
  assign pinOe         = st.oe;
  assign feedback      = cellResult; // R3
  assign clkGateData   = st.gateData; // R6
  assign s_axi_awready = st.awReady;
  assign s_axi_wready  = st.wReady;
  assign s_axi_bvalid  = st.bValid;
  assign s_axi_bresp   = st.bResp;
  assign s_axi_arready = st.arReady;
  assign s_axi_rvalid  = st.rValid;
  assign s_axi_rdata   = st.rData;
  assign s_axi_rresp   = st.rResp;

endmodule : mcl_block

// ==== src/mcl_cell.sv ====
// One macrocell: combinational, registered (D or T), latched or input capture storage.
`timescale 1ns/1ps
module mcl_cell
  import mcl_pkg::*;
#(
  parameter bit BURIED = 1'b0
) (
  // Clock and reset.
  input  wire logic      sys_clk,
  input  wire logic      sys_rst,
  // Configuration.
  input  wire mcl_mode_t mode,
  input  wire logic      invert,
  input  wire logic      toggle,
  input  wire logic      clkSel,
  input  wire logic      inLatch,
  // Logic and control inputs.
  input  wire logic      termSum,
  input  wire logic      extIn,
  input  wire logic      gateLevel,
  input  wire logic      gateRise,
  input  wire logic      blockReset,
  input  wire logic      blockPreset,
  // Result.
  output logic           result
);

  typedef struct packed {
    logic store;
    logic result;
  } mcl_cell_state_t;

  mcl_cell_state_t st;
  mcl_cell_state_t next_st;
  mcl_mode_t       effMode;

  // A mode of input capture is meaningful only in a buried cell; elsewhere it is combinational.
  assign effMode = (mode == MCL_MODE_INPUT && !BURIED) ? MCL_MODE_COMB : mode;

  // Next storage value and the presented result.
  always_comb begin
    next_st = st;
    case (effMode)
      MCL_MODE_REG: begin
        if (gateRise) begin // R7
          next_st.store = toggle ? (st.store ^ termSum) : termSum; // R4 R18
        end
      end
      MCL_MODE_LATCH: begin
        if (!gateLevel) begin // R9
          next_st.store = termSum;
        end // R8
      end
      MCL_MODE_INPUT: begin
        if (inLatch ? !gateLevel : gateRise) begin // R12
          next_st.store = extIn;
        end
      end
      default: begin
        next_st.store = termSum;
      end
    endcase
    if (blockReset) begin // R10 R16 R19
      next_st.store = 1'b0;
    end else if (blockPreset) begin // R10 R16
      next_st.store = 1'b1;
    end
    next_st.result = next_st.store ^ invert; // R1 R2 R3
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign result = st.result;

  // Clock select is used by the parent to pick gateLevel and gateRise.
  logic unusedSel;
  assign unusedSel = clkSel;

endmodule : mcl_cell

// ==== test/mcl_block_props.sv ====
// Checker of the macrocell logic block, bound to its ports.
`timescale 1ns/1ps
module mcl_block_props
  import mcl_pkg::*;
(
  // Clock, reset and logic side.
  input wire logic        sys_clk, sys_rst, resetTerm, presetTerm,
  input wire logic [15:0] termSum, feedback,
  input wire logic [1:0]  oeTerm, clkGatePin, clkGateData,
  input wire logic [7:0]  pinOut, pinOe, s_axi_awaddr,
  // Register bus.
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [1:0]  s_axi_bresp
);
  logic [7:0]  wa, oeExp;
  logic [31:0] wd, mode, ctl, oec;
  logic [1:0]  quiet;
  logic [15:0] comb, store;
  // Shadow of the setup and cycles since the write channels last moved.
  always_ff @(posedge sys_clk) begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
    if (sys_rst || s_axi_awvalid || s_axi_wvalid || s_axi_bvalid) quiet <= 2'h0;
    else if (quiet != 2'h3) quiet <= quiet + 2'h1;
    if (sys_rst) begin
      mode <= MCL_RST_MODE;
      ctl <= MCL_RST_CTRL;
      oec <= MCL_RST_OECFG;
    end else if (s_axi_bvalid && s_axi_bready) begin
      if (wa == MCL_OFF_MODE) mode <= wd;
      if (wa == MCL_OFF_CTRL) ctl <= wd;
      if (wa == MCL_OFF_OECFG) oec <= wd;
    end
  end
  // Cells by storage kind, and the pin drivers that the setup asks for.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      comb[i] = mode[2*i+:2] == 2'h0;
      store[i] = mode[2*i+:2] != 2'h0 && (i > 7 || mode[2*i+:2] != 2'h3);
    end
    for (int i = 0; i < 8; i++) begin
      oeExp[i] = oec[2*i+:2] == 2'h0 || (oec[2*i+1] && oeTerm[oec[2*i]]);
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence sBoth;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sRead;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_PIN_DATA: assert property (!$past(sys_rst) |-> clkGateData == $past(clkGatePin))
    else $error("clock pin data copy wrong");
  AST_PIN_MIRROR: assert property (pinOut == feedback[7:0])
    else $error("pin data differs from feedback");
  AST_COMB_PATH: assert property (quiet == 2'h3 |=>
    ((feedback ^ $past(termSum) ^ ctl[15:0]) & comb) == 16'h0)
    else $error("combinational cell result wrong");
  AST_RESET_WINS: assert property (resetTerm && quiet == 2'h3 |=>
    ((feedback ^ ctl[15:0]) & store) == 16'h0)
    else $error("reset term did not clear storage");
  AST_PRESET_ALL: assert property (presetTerm && !resetTerm && quiet == 2'h3 |=>
    ((feedback ^ ctl[15:0]) | ~store) == 16'hffff)
    else $error("preset term did not set storage");
  AST_OE_SELECT: assert property (quiet == 2'h3 |=> pinOe == $past(oeExp))
    else $error("pin driver enable wrong");
  AST_WRITE_RESP: assert property (sBoth |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_READ_ANSWER: assert property (sRead |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
endmodule : mcl_block_props

bind mcl_block mcl_block_props u_props (.*);

// ==== test/mcl_pin_model.sv ====
// Far-side driver of the pin cells and clock or gate pins.
`timescale 1ns/1ps
module mcl_pin_model (
  // Requests from the bench.
  input  wire logic [7:0] extVal,
  input  wire logic [7:0] extEn,
  input  wire logic [1:0] clkReq,
  // Pin cells of the block.
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  output logic      [7:0] pinIn,
  output logic      [1:0] clkGatePin
);
  // The block wins where it drives; a pin nobody drives is pulled high.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : (extEn[i] ? extVal[i] : 1'h1);
    end
    clkGatePin = clkReq;
  end
endmodule : mcl_pin_model

// ==== test/tb_top.sv ====
// Self-checking bench of the macrocell logic block.
`timescale 1ns/1ps
module tb_top
  import mcl_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} mcl_row_t;
  logic        sys_clk = 1'h0, sys_rst = 1'h1, resetTerm = 1'h0, presetTerm = 1'h0;
  logic [15:0] termSum = 16'h0, feedback;
  logic [1:0]  oeTerm = 2'h0, clkReq = 2'h0, clkGatePin, clkGateData;
  logic [7:0]  extVal = 8'h0, extEn = 8'h0, pinIn, pinOut, pinOe;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          failures = 0, checks = 0;
  mcl_row_t    rows [5] = '{'{MCL_OFF_MODE, MCL_RST_MODE, MCL_RESP_OKAY},
    '{MCL_OFF_CTRL, MCL_RST_CTRL, MCL_RESP_OKAY}, '{MCL_OFF_CLKSEL, MCL_RST_CLKSEL, MCL_RESP_OKAY},
    '{MCL_OFF_OECFG, MCL_RST_OECFG, MCL_RESP_OKAY}, '{8'h14, 32'h0, MCL_RESP_SLVERR}};

  mcl_block DUT (.*);
  mcl_pin_model PINS (.*);

  // Free-running system clock.
  always #5 sys_clk = ~sys_clk;

  // Compares one value and counts it.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // One bus write (w high) or read; a read also checks its data.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic ta, tw, ack, bv;
    logic [1:0] rsp;
    logic [31:0] got;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= 1'h0;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(negedge sys_clk);
      ta = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
      tw = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      ack = w ? (s_axi_bvalid && s_axi_bready) : s_axi_rvalid;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      got = s_axi_rdata;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (ta) s_axi_arvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (w && bv) s_axi_bready <= 1'h1;
    end while (!ack);
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    cmp({30'h0, rsp}, {30'h0, er});
    if (!w) cmp(got, d);
  endtask : bus

  // Waits n cycles, checks the feedback, then returns on a rising edge.
  task automatic look(input int n, input logic [15:0] exp);
    repeat (n) @(posedge sys_clk);
    #1 cmp({16'h0, feedback}, {16'h0, exp});
    @(posedge sys_clk);
  endtask : look

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // Main sequence: reset values, then each cell mode and the pin drivers.
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'h0;
    foreach (rows[i]) bus(1'h0, rows[i].a, rows[i].d, rows[i].r);
    bus(1'h1, 8'h14, 32'h1, MCL_RESP_SLVERR);
    bus(1'h1, MCL_OFF_STATUS, 32'hffff_ffff, MCL_RESP_OKAY);
    bus(1'h1, MCL_OFF_CTRL, 32'h0000_00ff, MCL_RESP_OKAY);
    termSum <= 16'ha5c3;
    look(4, 16'ha53c);
    bus(1'h1, MCL_OFF_CTRL, 32'h0, MCL_RESP_OKAY);
    bus(1'h1, MCL_OFF_MODE, 32'h5555_5555, MCL_RESP_OKAY);
    bus(1'h1, MCL_OFF_CLKSEL, 32'h0000_ff00, MCL_RESP_OKAY);
    resetTerm <= 1'h1;
    look(2, 16'h0);
    resetTerm <= 1'h0;
    termSum <= 16'hffff;
    look(4, 16'h0);
    clkReq <= 2'h1;
    look(4, 16'h00ff);
    clkReq <= 2'h3;
    look(4, 16'hffff);
    clkReq <= 2'h0;
    termSum <= 16'h0;
    look(4, 16'hffff);
    bus(1'h1, MCL_OFF_CTRL, 32'hffff_0000, MCL_RESP_OKAY);
    termSum <= 16'h0f0f;
    clkReq <= 2'h3;
    look(4, 16'hf0f0);
    resetTerm <= 1'h1;
    presetTerm <= 1'h1;
    look(4, 16'h0);
    resetTerm <= 1'h0;
    look(4, 16'hffff);
    presetTerm <= 1'h0;
    clkReq <= 2'h0;
    bus(1'h1, MCL_OFF_CTRL, 32'h0, MCL_RESP_OKAY);
    bus(1'h1, MCL_OFF_MODE, 32'haaaa_aaaa, MCL_RESP_OKAY);
    termSum <= 16'h1234;
    look(4, 16'h1234);
    clkReq <= 2'h3;
    look(2, 16'h1234);
    termSum <= 16'hedcb;
    look(4, 16'h1234);
    clkReq <= 2'h0;
    look(4, 16'hedcb);
    bus(1'h1, MCL_OFF_MODE, 32'hffff_ffff, MCL_RESP_OKAY);
    extEn <= 8'hff;
    extVal <= 8'h5a;
    termSum <= 16'h0033;
    clkReq <= 2'h2;
    look(4, 16'h5a33);
    bus(1'h1, MCL_OFF_CLKSEL, 32'h00ff_ff00, MCL_RESP_OKAY);
    clkReq <= 2'h0;
    extVal <= 8'hc3;
    look(4, 16'hc333);
    bus(1'h1, MCL_OFF_OECFG, 32'h0000_55e4, MCL_RESP_OKAY);
    for (int t = 0; t < 4; t++) begin
      oeTerm <= t[1:0];
      repeat (3) @(posedge sys_clk);
      #1 cmp({24'h0, pinOe}, {28'h0, t[1:0], 2'h1});
      @(posedge sys_clk);
    end
    finish_test();
  end

  // Cuts a hung run short.
  initial begin
    #100us;
    failures++;
    finish_test();
  end
endmodule : tb_top
